// *** logic/pmc_ctrl.sv ***
// Serial management command block: on/margin, on/off source, lock, store
//
// Behaviour
// - The fault-clearing command zeroes every latched fault flag.
// - The fault-clearing command releases the open-drain alert line.
// - Lock bit 5 set rejects writes except lock, on/margin and on/off config.
// - Lock bit 6 cleared adds no write restriction of its own.
// - Store request copies the register named by the data byte to memory.
// - Stored copy lives in own non-volatile memory, surviving reset.
// - Lock bit 7 set rejects all writes except to the lock register.
`timescale 1ns/1ps
module pmc_ctrl #(
	parameter logic [6:0] BUS_ADDR = pmc_pkg::DEV_ADDR
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic onoff_pin_in,
	input wire logic [pmc_pkg::FAULT_W-1:0] fault_event_in,
	output logic [pmc_pkg::FAULT_W-1:0] fault_flags_out,
	output logic alert_out,
	output logic alert_oe_out,
	output logic power_on_out,
	output logic [pmc_pkg::MARGIN_W-1:0] margin_out,
	output logic store_ok_out
);
	import pmc_pkg::*;

	function automatic logic write_allowed(logic [7:0] lk, logic [7:0] code);
		logic ok;
		ok = 1'b1;
		if (lk[LOCK_ALL_BIT]) begin
			ok = (code == CODE_LOCK);
		end else if (lk[LOCK_OP_BIT]) begin
			ok = (code == CODE_LOCK) || (code == CODE_OP);
		end else if (lk[LOCK_CFG_BIT]) begin
			ok = (code == CODE_LOCK) || (code == CODE_OP)
				|| (code == CODE_ONOFF);
		end
		return ok;
	endfunction

	function automatic logic [NVM_AW:0] slot_of(logic [7:0] code);
		logic [NVM_AW:0] s;
		s = {1'b0, SLOT_OP};
		unique case (code)
			CODE_OP: s = {1'b1, SLOT_OP};
			CODE_ONOFF: s = {1'b1, SLOT_ONOFF};
			CODE_LOCK: s = {1'b1, SLOT_LOCK};
			default: s = {1'b0, SLOT_OP};
		endcase
		return s;
	endfunction

	// Two flops before use; the third only remembers the old level
	logic [2:0] scl_sy_r, sda_sy_r;
	logic [1:0] pin_sy_r;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
			pin_sy_r <= 2'h0;
		end else begin
			scl_sy_r <= {scl_sy_r[1:0], scl_in};
			sda_sy_r <= {sda_sy_r[1:0], sda_in};
			pin_sy_r <= {pin_sy_r[0], onoff_pin_in};
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
	assign sda_now = sda_sy_r[1];
	assign scl_rise = scl_sy_r[1] & ~scl_sy_r[2];
	assign scl_fall = ~scl_sy_r[1] & scl_sy_r[2];
	assign bus_start = scl_sy_r[1] & scl_sy_r[2] & ~sda_now & sda_sy_r[2];
	assign bus_stop = scl_sy_r[1] & scl_sy_r[2] & sda_now & ~sda_sy_r[2];

	pmc_state_t st_r, st_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt;
	logic [1:0] idx_r, idx_nxt, chk_r, chk_nxt;
	logic rd_r, rd_nxt, ack_r, ack_nxt, oe_r, oe_nxt;
	logic [7:0] op_r, op_nxt, cfg_r, cfg_nxt, lk_r, lk_nxt;
	logic [FAULT_W-1:0] flt_r, flt_nxt;
	logic alert_r, alert_nxt, pwr_r, pwr_nxt, ok_r, ok_nxt;
	logic [NVM_AW-1:0] slot_r, slot_nxt;
	logic [7:0] exp_r, exp_nxt;
	logic [7:0] rx_byte, rd_val, mem_rdata;
	logic byte_done, wr_go, clr_go, store_go, mem_we, mem_re, pin_on;
	logic [NVM_AW:0] st_slot;

	assign rx_byte = {sh_r[6:0], sda_now};
	assign byte_done = (st_r == PMC_RX) && scl_rise && (bit_r == BIT_LAST);
	assign wr_go = byte_done && (idx_r == IDX_DATA) && !rd_r
		&& write_allowed(lk_r, cmd_r);
	assign clr_go = byte_done && (idx_r == IDX_CMD)
		&& (rx_byte == CODE_CLEAR) && write_allowed(lk_r, rx_byte);
	assign st_slot = slot_of(rx_byte);
	assign store_go = wr_go && (cmd_r == CODE_STORE) && st_slot[NVM_AW];
	assign mem_we = store_go;
	assign mem_re = (chk_r == 2'h1);
	assign pin_on = (pin_sy_r[1] == cfg_r[POL_BIT]);

	always_comb begin
		unique case (cmd_r)
			CODE_OP: rd_val = op_r;
			CODE_ONOFF: rd_val = cfg_r;
			CODE_LOCK: rd_val = lk_r;
			default: rd_val = READ_NONE;
		endcase
	end

	// Store target value: the working register picked by the data byte
	logic [7:0] store_val;
	always_comb begin
		unique case (st_slot[NVM_AW-1:0])
			SLOT_ONOFF: store_val = cfg_r;
			SLOT_LOCK: store_val = lk_r;
			default: store_val = op_r;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		cmd_nxt = cmd_r;
		idx_nxt = idx_r;
		rd_nxt = rd_r;
		ack_nxt = ack_r;
		oe_nxt = oe_r;
		unique case (st_r)
			PMC_IDLE: ;
			PMC_RX: if (scl_rise) begin
				sh_nxt = rx_byte;
				bit_nxt = bit_r + 3'h1;
				if (bit_r == BIT_LAST) begin
					st_nxt = PMC_ACK_SET;
					ack_nxt = 1'b1;
					if (idx_r == IDX_ADDR) begin
						ack_nxt = (rx_byte[7:1] == BUS_ADDR);
						rd_nxt = rx_byte[0];
					end else if (idx_r == IDX_CMD) begin
						cmd_nxt = rx_byte;
					end
					if (idx_r != IDX_DATA) begin
						idx_nxt = idx_r + 2'h1;
					end
				end
			end
			PMC_ACK_SET: if (scl_fall) begin
				oe_nxt = ack_r;
				st_nxt = ack_r ? PMC_ACK_HOLD : PMC_IDLE;
			end
			PMC_ACK_HOLD: if (scl_fall) begin
				bit_nxt = 3'h0;
				if (rd_r && idx_r == IDX_CMD) begin
					// Read answers with the register named by the command
					sh_nxt = rd_val;
					oe_nxt = ~rd_val[7];
					st_nxt = PMC_TX;
				end else begin
					oe_nxt = 1'b0;
					st_nxt = PMC_RX;
				end
			end
			PMC_TX: begin
				if (scl_rise) begin
					bit_nxt = bit_r + 3'h1;
					if (bit_r == BIT_LAST) begin
						st_nxt = PMC_TX_ACK;
					end
				end
				if (scl_fall) begin
					sh_nxt = {sh_r[6:0], 1'b0};
					oe_nxt = ~sh_r[6];
				end
			end
			PMC_TX_ACK: if (scl_fall) begin
				oe_nxt = 1'b0;
				st_nxt = PMC_IDLE;
			end
		endcase
		// Start and stop override any byte in flight
		if (bus_start) begin
			st_nxt = PMC_RX;
			bit_nxt = 3'h0;
			idx_nxt = IDX_ADDR;
			oe_nxt = 1'b0;
		end else if (bus_stop) begin
			st_nxt = PMC_IDLE;
			oe_nxt = 1'b0;
		end
	end

	always_comb begin
		op_nxt = op_r;
		cfg_nxt = cfg_r;
		lk_nxt = lk_r;
		if (wr_go) begin
			unique case (cmd_r)
				CODE_OP: op_nxt = (op_r & ~OP_WMASK) | (rx_byte & OP_WMASK);
				CODE_ONOFF: cfg_nxt = (cfg_r & ~ONOFF_WMASK)
					| (rx_byte & ONOFF_WMASK);
				CODE_LOCK: lk_nxt = rx_byte & LOCK_WMASK;
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		flt_nxt = (clr_go ? '0 : flt_r) | fault_event_in;
		alert_nxt = |flt_nxt;
		if (!cfg_r[PU_BIT]) begin
			pwr_nxt = 1'b1;
		end else begin
			pwr_nxt = (!cfg_r[CMD_BIT] || op_r[OP_ON_BIT])
				&& (!cfg_r[CPR_BIT] || pin_on);
		end
		// Read back the stored word to confirm the memory took it
		slot_nxt = store_go ? st_slot[NVM_AW-1:0] : slot_r;
		exp_nxt = store_go ? store_val : exp_r;
		chk_nxt = store_go ? 2'h1 : (chk_r == 2'h0 ? 2'h0 : chk_r + 2'h1);
		ok_nxt = ok_r;
		if (store_go) begin
			ok_nxt = 1'b0;
		end else if (chk_r == 2'h2) begin
			ok_nxt = (mem_rdata == exp_r);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= PMC_IDLE;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			idx_r <= IDX_ADDR;
			rd_r <= 1'b0;
			ack_r <= 1'b0;
			oe_r <= 1'b0;
			op_r <= OP_RESET;
			cfg_r <= ONOFF_RESET;
			lk_r <= LOCK_RESET;
			flt_r <= '0;
			alert_r <= 1'b0;
			pwr_r <= 1'b0;
			slot_r <= SLOT_OP;
			exp_r <= 8'h00;
			chk_r <= 2'h0;
			ok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			cmd_r <= cmd_nxt;
			idx_r <= idx_nxt;
			rd_r <= rd_nxt;
			ack_r <= ack_nxt;
			oe_r <= oe_nxt;
			op_r <= op_nxt;
			cfg_r <= cfg_nxt;
			lk_r <= lk_nxt;
			flt_r <= flt_nxt;
			alert_r <= alert_nxt;
			pwr_r <= pwr_nxt;
			slot_r <= slot_nxt;
			exp_r <= exp_nxt;
			chk_r <= chk_nxt;
			ok_r <= ok_nxt;
		end
	end

	// Memory has no reset so a stored default outlives a device reset
	pmc_nvm #(.AW(NVM_AW), .DW(8)) u_nvm (
		.clk_sys_in(clk_sys_in),
		.we_in(mem_we),
		.waddr_in(st_slot[NVM_AW-1:0]),
		.wdata_in(store_val),
		.re_in(mem_re),
		.raddr_in(slot_r),
		.rdata_out(mem_rdata)
	);

	assign sda_out = 1'b0;
	assign sda_oe_out = oe_r;
	assign alert_out = 1'b0;
	assign alert_oe_out = alert_r;
	assign fault_flags_out = flt_r;
	assign power_on_out = pwr_r;
	assign margin_out = op_r[MARGIN_LSB +: MARGIN_W];
	assign store_ok_out = ok_r;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	chk_clear_flags: assert property (
		clr_go |=> fault_flags_out == $past(fault_event_in))
		else $error("fault flags not cleared");
	chk_alert_release: assert property (
		clr_go && fault_event_in == '0 |=> !alert_oe_out)
		else $error("alert still driven after clear");
	chk_cfg_lock: assert property (
		wr_go |-> !(lk_r[LOCK_CFG_BIT] && cmd_r == CODE_STORE))
		else $error("write passed config lock");
	chk_cfg_open: assert property (
		byte_done && idx_r == IDX_DATA && !rd_r && lk_r[LOCK_CFG_BIT]
		&& !lk_r[LOCK_OP_BIT] && !lk_r[LOCK_ALL_BIT] && cmd_r == CODE_ONOFF
		|=> (cfg_r & ONOFF_WMASK) == ($past(rx_byte) & ONOFF_WMASK))
		else $error("config write lost under config lock");
	chk_lock_open: assert property (
		byte_done && idx_r == IDX_DATA && !rd_r && lk_r == 8'h00
		&& cmd_r == CODE_OP |=> op_r == ($past(rx_byte) & OP_WMASK))
		else $error("unlocked write lost");
	chk_store_copy: assert property (
		store_go |-> store_val == (rx_byte == CODE_ONOFF ? cfg_r
			: rx_byte == CODE_LOCK ? lk_r : op_r))
		else $error("store copied wrong value");
	chk_store_keep: assert property (
		store_go |=> ##2 store_ok_out)
		else $error("stored word not kept");
	chk_all_lock: assert property (
		byte_done && idx_r == IDX_DATA && lk_r[LOCK_ALL_BIT]
		&& cmd_r != CODE_LOCK |=> $stable(op_r) && $stable(cfg_r))
		else $error("write passed full lock");
	chk_cmd_on: assert property (
		cfg_r[PU_BIT] && cfg_r[CMD_BIT] && !cfg_r[CPR_BIT]
		&& $stable(cfg_r) |=> power_on_out == $past(op_r[OP_ON_BIT]))
		else $error("output not following on bit");

	cov_clear: cover property (clr_go);
	cov_store: cover property (store_go ##3 store_ok_out);
	cov_read: cover property (st_r == PMC_TX ##[1:200] st_r == PMC_TX_ACK);
endmodule

// *** logic/pmc_pkg.sv ***
// Constants shared by the power module control command block
package pmc_pkg;
	localparam logic [7:0] CODE_OP = 8'h01;
	localparam logic [7:0] CODE_ONOFF = 8'h02;
	localparam logic [7:0] CODE_CLEAR = 8'h03;
	localparam logic [7:0] CODE_LOCK = 8'h10;
	localparam logic [7:0] CODE_STORE = 8'h13;
	// Reset values and writable-bit masks of the working registers
	localparam logic [7:0] OP_RESET = 8'h00;
	localparam logic [7:0] OP_WMASK = 8'hbc;
	localparam logic [7:0] ONOFF_RESET = 8'h17;
	localparam logic [7:0] ONOFF_WMASK = 8'h1e;
	localparam logic [7:0] LOCK_RESET = 8'h00;
	localparam logic [7:0] LOCK_WMASK = 8'he0;
	localparam logic [7:0] READ_NONE = 8'h00;
	// Field positions
	localparam int OP_ON_BIT = 7;
	localparam int MARGIN_LSB = 2;
	localparam int MARGIN_W = 4;
	localparam int PU_BIT = 4;
	localparam int CMD_BIT = 3;
	localparam int CPR_BIT = 2;
	localparam int POL_BIT = 1;
	localparam int LOCK_ALL_BIT = 7;
	localparam int LOCK_OP_BIT = 6;
	localparam int LOCK_CFG_BIT = 5;
	// Non-volatile slots, one per storable register
	localparam int NVM_AW = 2;
	localparam logic [NVM_AW-1:0] SLOT_OP = 2'h0;
	localparam logic [NVM_AW-1:0] SLOT_ONOFF = 2'h1;
	localparam logic [NVM_AW-1:0] SLOT_LOCK = 2'h2;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] IDX_ADDR = 2'h0;
	localparam logic [1:0] IDX_CMD = 2'h1;
	localparam logic [1:0] IDX_DATA = 2'h2;
	localparam logic [6:0] DEV_ADDR = 7'h28;
	localparam int FAULT_W = 8;
	typedef enum logic [2:0] {
		PMC_IDLE, PMC_RX, PMC_ACK_SET, PMC_ACK_HOLD, PMC_TX, PMC_TX_ACK
	} pmc_state_t;
endpackage

// *** logic/pmc_nvm.sv ***
// Small non-volatile store: contents are not touched by reset
`timescale 1ns/1ps
module pmc_nvm #(
	parameter int AW = 2,
	parameter int DW = 8
) (
	input wire logic clk_sys_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [DW-1:0] wdata_in,
	input wire logic re_in,
	input wire logic [AW-1:0] raddr_in,
	output logic [DW-1:0] rdata_out
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_r;

	always_ff @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		if (re_in) begin
			rdata_r <= mem[raddr_in];
		end
	end

	assign rdata_out = rdata_r;
endmodule

// *** verif/pmc_host.sv ***
// Bus host model: drives clock and data of the management bus
`timescale 1ns/1ps
module pmc_host (
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_pull_out
);
	logic [6:0] addr = 7'h28;
	logic busy = 1'b0;
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// Data moves mid-low so the synced scl rise sees it settled
	task automatic bit_io(input logic b, output logic s);
		scl_out = 1'b0;
		#20 sda_pull_out = !b;
		#42.5 scl_out = 1'b1;
		s = sda_in;
		#62.5;
	endtask
	// Clock stands high between frames, so only a repeat start drops it
	task automatic start();
		if (busy) begin
			scl_out = 1'b0;
			#20 sda_pull_out = 1'b0;
			#42.5 scl_out = 1'b1;
			#62.5;
		end
		sda_pull_out = 1'b1;
		busy = 1'b1;
		#62.5;
	endtask
	task automatic stop();
		scl_out = 1'b0;
		#20 sda_pull_out = 1'b1;
		#42.5 scl_out = 1'b1;
		#62.5 sda_pull_out = 1'b0;
		busy = 1'b0;
		#62.5;
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(1'b1, nak);
	endtask
	task automatic wr(input logic [7:0] c, d, input logic two,
		output logic ok);
		logic [7:0] q;
		logic n0, n1, n2;
		start();
		xfer({addr, 1'b0}, q, n0);
		xfer(c, q, n1);
		n2 = 1'b0;
		if (two) xfer(d, q, n2);
		stop();
		ok = !(n0 | n1 | n2);
	endtask
	// Last bit of a read is the host's refusal, so it is not an ack
	task automatic rd(input logic [7:0] c, output logic [7:0] q,
		output logic ok);
		logic n0, n1, n2, n3;
		start();
		xfer({addr, 1'b0}, q, n0);
		xfer(c, q, n1);
		start();
		xfer({addr, 1'b1}, q, n2);
		xfer(8'hff, q, n3);
		stop();
		ok = !(n0 | n1 | n2);
	endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the power module control command block
`timescale 1ns/1ps
module tb_top;
	import pmc_pkg::*;
	logic clk_sys_in, rst_b_in, pin, scl, pull, sda_o, sda_oe, alert_o;
	logic alert_oe, pwr, ok_st, ok, sda_w;
	logic [7:0] ev, flags, q, d, op_m, on_m, lk_m, fl_m;
	logic [7:0] nv_m[3];
	logic [3:0] margin;
	logic [7:0] lks[5] = '{8'h80, 8'h40, 8'h20, 8'hff, 8'h00};
	logic [7:0] codes[3] = '{CODE_OP, CODE_ONOFF, CODE_LOCK};
	integer seed = 70;
	int n_errors = 0;
	int n_compared = 0;
	// Open-drain wire with pull-up: released means high
	assign sda_w = (sda_oe ? sda_o : 1'b1) & !pull;
	pmc_ctrl pmc_ctrl_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.onoff_pin_in(pin), .fault_event_in(ev), .fault_flags_out(flags),
		.alert_out(alert_o), .alert_oe_out(alert_oe), .power_on_out(pwr),
		.margin_out(margin), .store_ok_out(ok_st));
	pmc_host pmc_host_i (.sda_in(sda_w), .scl_out(scl),
		.sda_pull_out(pull));
	task automatic check(input logic [7:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t %s saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic may_wr(input logic [7:0] lk, c);
		if (c == CODE_LOCK) return 1'b1;
		if (lk[LOCK_ALL_BIT]) return 1'b0;
		if (lk[LOCK_OP_BIT]) return c == CODE_OP;
		if (lk[LOCK_CFG_BIT]) return c == CODE_OP || c == CODE_ONOFF;
		return 1'b1;
	endfunction
	function automatic logic [7:0] merge(input logic [7:0] o, v, m);
		return (o & ~m) | (v & m);
	endfunction
	function automatic logic exp_pwr();
		if (!on_m[PU_BIT]) return 1'b1;
		return (!on_m[CMD_BIT] || op_m[OP_ON_BIT]) &&
			(!on_m[CPR_BIT] || pin == on_m[POL_BIT]);
	endfunction
	task automatic put(input logic [7:0] c, v);
		pmc_host_i.wr(c, v, 1'b1, ok);
		check(ok, 1'b1, "write ack");
		if (may_wr(lk_m, c)) begin
			if (c == CODE_OP) op_m = merge(op_m, v, OP_WMASK);
			if (c == CODE_ONOFF) on_m = merge(on_m, v, ONOFF_WMASK);
			if (c == CODE_LOCK) lk_m = merge(lk_m, v, LOCK_WMASK);
		end
	endtask
	task automatic get_all();
		foreach (codes[k]) begin
			pmc_host_i.rd(codes[k], q, ok);
			check(ok, 1'b1, "read ack");
			check(q, k == 0 ? op_m : k == 1 ? on_m : lk_m, "read");
		end
		check(margin, op_m[5:2], "margin");
		check(pwr, exp_pwr(), "power");
	endtask
	task automatic do_reset();
		@(posedge clk_sys_in);
		#1 rst_b_in = 1'b0;
		op_m = OP_RESET;
		on_m = ONOFF_RESET;
		lk_m = LOCK_RESET;
		fl_m = 8'h00;
		repeat (5) @(posedge clk_sys_in);
		#1 rst_b_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		// Keep host edges off the sampling edge of the system clock
		#1;
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = !clk_sys_in;
	end
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		rst_b_in = 1'b0;
		pin = 1'b1;
		ev = 8'h00;
		do_reset();
		get_all();
		$display("test reset done");
		foreach (lks[k]) begin
			put(CODE_LOCK, lks[k]);
			repeat (3) begin
				put(CODE_OP, 8'($random(seed)));
				put(CODE_ONOFF, 8'($random(seed)));
				pin = 1'($random(seed));
				get_all();
			end
			$display("test lock %h done", lks[k]);
		end
		// Bus command control: only the top on/margin bit switches output
		put(CODE_ONOFF, 8'h18);
		put(CODE_OP, 8'h80);
		get_all();
		put(CODE_OP, 8'h7c);
		get_all();
		$display("test command control done");
		// A locked clear must leave the flags standing; the unlocked pass (lock 00) clears them
		foreach (lks[k]) begin
			put(CODE_LOCK, lks[k]);
			d = 8'($random(seed)) | 8'h01;
			@(posedge clk_sys_in);
			#1 ev = d;
			@(posedge clk_sys_in);
			#1 ev = 8'h00;
			// Refused clears leave earlier flags standing
			fl_m = fl_m | d;
			repeat (2) @(posedge clk_sys_in);
			#1 check(alert_oe, 1'b1, "alert set");
			pmc_host_i.wr(CODE_CLEAR, 8'h00, 1'b0, ok);
			if (may_wr(lk_m, CODE_CLEAR)) fl_m = 8'h00;
			check(flags, fl_m, "flags");
			check(alert_oe, |fl_m, "alert");
			check(alert_o, 1'b0, "alert level");
		end
		$display("test clear done");
		foreach (codes[k]) begin
			put(CODE_STORE, codes[k]);
			nv_m[k] = k == 0 ? op_m : k == 1 ? on_m : lk_m;
			check(ok_st, 1'b1, "store");
			check(pmc_ctrl_i.u_nvm.mem[k], nv_m[k], "stored");
		end
		$display("test store done");
		pmc_host_i.addr = DEV_ADDR ^ 7'h01;
		pmc_host_i.wr(CODE_OP, 8'hbc, 1'b1, ok);
		check(ok, 1'b0, "foreign address");
		pmc_host_i.addr = DEV_ADDR;
		get_all();
		do_reset();
		check(ok_st, 1'b0, "store flag reset");
		foreach (codes[k]) begin
			check(pmc_ctrl_i.u_nvm.mem[k], nv_m[k], "kept");
		end
		get_all();
		$display("test address and reset done");
		tally_and_finish();
	end
endmodule
